// >>> src/tccad_pkg.sv
/*
 Constants, enumerations and state layout for the CC attach and orientation
 detection logic. Assumes analog comparators outside report per-pin levels.
*/
package tccad_pkg;

   // Timing: debounce and overvoltage shutdown
   localparam int unsigned CLK_FREQ_HZ               = 50_000_000;
   localparam int unsigned DEBOUNCE_TIME_US          = 150;
   localparam int unsigned DEBOUNCE_CYCLES           =
      DEBOUNCE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int unsigned SHUTDOWN_TIME_NS          = 20;
   localparam int unsigned SHUTDOWN_CYCLES_RAW       =
      SHUTDOWN_TIME_NS * (CLK_FREQ_HZ / 1_000_000) / 1000;
   localparam int unsigned SHUTDOWN_CYCLES           = (SHUTDOWN_CYCLES_RAW < 1) ? 1 : SHUTDOWN_CYCLES_RAW;
   localparam int unsigned DEB_W                     = 14;
   localparam logic [DEB_W-1:0] DEB_ZERO             = 14'h0000;
   localparam logic [DEB_W-1:0] DEB_ONE              = 14'h0001;

   // Comparator reference select codes
   localparam logic [1:0] REF_SRC_LOW                = 2'h0;
   localparam logic [1:0] REF_SRC_HIGH               = 2'h1;
   localparam logic [1:0] REF_SNK                    = 2'h2;

   // Pin termination classes
   typedef enum logic [1:0] {TERM_OPEN, TERM_RD, TERM_RA} tccad_term_t;

   // Attach state machine
   typedef enum logic [2:0] {
      ST_UNATTACHED, ST_SINK_ATT, ST_CABLE_SINK, ST_CABLE_ONLY, ST_SNK_WAIT, ST_SNK_ATT
   } tccad_state_t;

   // Module state apart from the partner_level register
   typedef struct packed {
      tccad_state_t      state;
      logic              orient;      // 0: pin one carries the sink
      logic [DEB_W-1:0]  deb_cnt;
      logic [2:0]        s_one_open;
      logic [2:0]        s_one_ra;
      logic [2:0]        s_two_open;
      logic [2:0]        s_two_ra;
      logic [2:0]        s_ovp;
      logic [2:0]        s_vbus;
      logic              vbus_en;
      logic              vconn_one;
      logic              vconn_two;
      logic              tx_dis;
      logic              high_level;
      logic              attached;
      logic              cable_seen;
      logic              detach_pulse;
   } tccad_regs_t;

endpackage : tccad_pkg

// >>> src/tccad_attach.sv
/*
 CC attach, orientation, debounce and overvoltage logic for one Type-C port.
 Assumes comparator outputs arrive asynchronously and are synchronised here;
 the analog front end applies the reference and pull terminations requested.
*/
`timescale 1ns/1ps
module tccad_attach
   import tccad_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   // Role and firmware control
   input  wire logic        sink_role_in,
   input  wire logic        regulator_at_5v_in,
   input  wire logic        high_level_req_in,
   // Comparators: above open/disconnect threshold, below marked cable threshold
   input  wire logic        pin_one_above_disc_in,
   input  wire logic        pin_one_below_marked_in,
   input  wire logic        pin_two_above_disc_in,
   input  wire logic        pin_two_below_marked_in,
   input  wire logic        cc_overvoltage_in,
   input  wire logic        port_bus_power_present_in,
   input  wire logic [1:0]  partner_level_in,
   // Analog control
   output logic [1:0]       comparator_ref_out,
   output logic             pullup_enable_out,
   output logic             pullup_high_level_out,
   output logic             sink_pulldown_out,
   // Power and transmitter control
   output logic             port_bus_power_en_out,
   output logic             vconn_pin_one_out,
   output logic             vconn_pin_two_out,
   output logic             pd_tx_disable_out,
   // Status
   output logic             attached_out,
   output logic             orientation_out,
   output logic             cable_present_out,
   output logic [1:0]       partner_level_out,
   output logic             detach_event_out
);

   tccad_regs_t r;
   tccad_regs_t next_r;
   logic [1:0]  partner_level;

   // Last stage takes a new level only once the two stages before it agree
   function automatic logic settled(input logic [2:0] s, input logic old);
      settled = (s[0] == s[1]) ? s[1] : old;
   endfunction : settled

   // Termination class from comparators; Ra wins below marked threshold
   function automatic tccad_term_t classify(input logic open_lvl, input logic ra_lvl);
      if (ra_lvl) begin
         classify = TERM_RA;
      end else if (open_lvl) begin
         classify = TERM_OPEN;
      end else begin
         classify = TERM_RD;
      end
   endfunction : classify

   logic        one_open, one_ra, two_open, two_ra, ovp, vbus;
   tccad_term_t t_one, t_two;
   logic        watch_high;

   assign one_open = r.s_one_open[2];
   assign one_ra   = r.s_one_ra[2];
   assign two_open = r.s_two_open[2];
   assign two_ra   = r.s_two_ra[2];
   assign ovp      = r.s_ovp[2];
   assign vbus     = r.s_vbus[2];
   assign t_one    = classify(one_open, one_ra);
   assign t_two    = classify(two_open, two_ra);
   // Monitored pin above disconnect threshold; Ra pin counts as detach only in ST_CABLE_ONLY
   assign watch_high = r.orient ? two_open : one_open;

   // Next-state logic
   always_comb begin
      next_r = r;
      next_r.detach_pulse = 1'b0;
      // Three-stage synchronisers; logic reads only the filtered last stage
      next_r.s_one_open = {r.s_one_open[1:0], pin_one_above_disc_in};
      next_r.s_one_ra   = {r.s_one_ra[1:0], pin_one_below_marked_in};
      next_r.s_two_open = {r.s_two_open[1:0], pin_two_above_disc_in};
      next_r.s_two_ra   = {r.s_two_ra[1:0], pin_two_below_marked_in};
      next_r.s_ovp      = {r.s_ovp[1:0], cc_overvoltage_in};
      next_r.s_vbus     = {r.s_vbus[1:0], port_bus_power_present_in};
      next_r.s_one_open[2] = settled(r.s_one_open, r.s_one_open[2]);
      next_r.s_one_ra[2]   = settled(r.s_one_ra, r.s_one_ra[2]);
      next_r.s_two_open[2] = settled(r.s_two_open, r.s_two_open[2]);
      next_r.s_two_ra[2]   = settled(r.s_two_ra, r.s_two_ra[2]);
      next_r.s_ovp[2]      = settled(r.s_ovp, r.s_ovp[2]);
      next_r.s_vbus[2]     = settled(r.s_vbus, r.s_vbus[2]);

      // Pull-up level: low in sink role or until regulator reaches 5 V, then firmware's pick
      if (!regulator_at_5v_in || sink_role_in) begin
         next_r.high_level = 1'b0;
      end else begin
         next_r.high_level = high_level_req_in;
      end

      case (r.state)
         ST_UNATTACHED: begin
            // Both open: keep watching, everything off
            next_r.vbus_en   = 1'b0;
            next_r.vconn_one = 1'b0;
            next_r.vconn_two = 1'b0;
            next_r.attached  = 1'b0;
            next_r.cable_seen = 1'b0;
            next_r.deb_cnt   = DEB_ZERO;
            if (sink_role_in) begin
               next_r.state = ST_SNK_WAIT;
            end else if (t_one == TERM_RD && t_two != TERM_RD) begin
               next_r.state    = (t_two == TERM_RA) ? ST_CABLE_SINK : ST_SINK_ATT;
               next_r.orient   = 1'b0;
               next_r.vbus_en  = 1'b1;
               next_r.vconn_two = (t_two == TERM_RA) && !ovp;
               next_r.attached = 1'b1;
               next_r.cable_seen = (t_two == TERM_RA);
            end else if (t_two == TERM_RD && t_one != TERM_RD) begin
               next_r.state    = (t_one == TERM_RA) ? ST_CABLE_SINK : ST_SINK_ATT;
               next_r.orient   = 1'b1;
               next_r.vbus_en  = 1'b1;
               next_r.vconn_one = (t_one == TERM_RA) && !ovp;
               next_r.attached = 1'b1;
               next_r.cable_seen = (t_one == TERM_RA);
            end else if (t_one == TERM_RA && t_two == TERM_OPEN) begin
               next_r.state = ST_CABLE_ONLY;
               next_r.orient = 1'b1;
               next_r.cable_seen = 1'b1;
            end else if (t_two == TERM_RA && t_one == TERM_OPEN) begin
               next_r.state = ST_CABLE_ONLY;
               next_r.orient = 1'b0;
               next_r.cable_seen = 1'b1;
            end
         end
         ST_SINK_ATT, ST_CABLE_SINK: begin
            // Debounce the Rd pin rising past the disconnect threshold
            if (sink_role_in) begin
               next_r.state = ST_UNATTACHED;
            end else if (watch_high) begin
               next_r.deb_cnt = r.deb_cnt + DEB_ONE;
               if (r.deb_cnt >= DEB_W'(DEBOUNCE_CYCLES - 1)) begin
                  next_r.state = ST_UNATTACHED;
                  next_r.vbus_en = 1'b0;
                  next_r.vconn_one = 1'b0;
                  next_r.vconn_two = 1'b0;
                  next_r.attached = 1'b0;
                  next_r.deb_cnt = DEB_ZERO;
                  next_r.detach_pulse = 1'b1;
               end
            end else begin
               next_r.deb_cnt = DEB_ZERO;
            end
         end
         ST_CABLE_ONLY: begin
            // Open pin watched for sink, Ra pin for cable removal
            next_r.vbus_en = 1'b0;
            next_r.vconn_one = 1'b0;
            next_r.vconn_two = 1'b0;
            if (sink_role_in || (r.orient ? !one_ra : !two_ra)) begin
               next_r.state = ST_UNATTACHED;
               next_r.cable_seen = 1'b0;
               next_r.detach_pulse = 1'b1;
            end else if ((r.orient ? t_two : t_one) == TERM_RD) begin
               next_r.state = ST_CABLE_SINK;
               next_r.vbus_en = 1'b1;
               next_r.vconn_one = r.orient && !ovp;
               next_r.vconn_two = !r.orient && !ovp;
               next_r.attached = 1'b1;
               next_r.orient = r.orient;
            end
         end
         ST_SNK_WAIT: begin
            // Sink: attach by bus voltage only
            if (!sink_role_in) begin
               next_r.state = ST_UNATTACHED;
            end else if (vbus) begin
               next_r.state = ST_SNK_ATT;
               next_r.attached = 1'b1;
               next_r.orient = !one_open && two_open;
            end
         end
         ST_SNK_ATT: begin
            if (!vbus || !sink_role_in) begin
               next_r.state = ST_UNATTACHED;
               next_r.attached = 1'b0;
               next_r.detach_pulse = 1'b1;
            end
         end
         default: begin
            next_r.state = ST_UNATTACHED;
         end
      endcase

      // Overvoltage overrides VCONN and transmitter in the same cycle it settles
      next_r.tx_dis = ovp;
      if (ovp) begin
         next_r.vconn_one = 1'b0;
         next_r.vconn_two = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         r <= '{state: ST_UNATTACHED, default: '0};
      end else begin
         r <= next_r;
      end
   end

   // Partner advertisement captured while attached as sink
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         partner_level <= 2'h0;
      end else if (r.state == ST_SNK_ATT) begin
         partner_level <= partner_level_in;
      end else begin
         partner_level <= 2'h0;
      end
   end

   // Outputs; overvoltage also gates VCONN combinationally for fast shutdown
   assign comparator_ref_out    = sink_role_in ? REF_SNK :
                                  (r.high_level ? REF_SRC_HIGH : REF_SRC_LOW);
   assign pullup_enable_out     = !sink_role_in;
   assign pullup_high_level_out = r.high_level;
   assign sink_pulldown_out     = sink_role_in;
   assign port_bus_power_en_out = r.vbus_en;
   assign vconn_pin_one_out     = r.vconn_one && !ovp;
   assign vconn_pin_two_out     = r.vconn_two && !ovp;
   assign pd_tx_disable_out     = r.tx_dis | ovp;
   assign attached_out          = r.attached;
   assign orientation_out       = r.orient;
   assign cable_present_out     = r.cable_seen;
   assign partner_level_out     = partner_level;
   assign detach_event_out      = r.detach_pulse;

endmodule : tccad_attach

// >>> verification/tccad_cable_model.sv
/*
 Behavioural cable or partner seen on the two CC pins.
 Assumes the bench picks each pin's termination.
*/
`timescale 1ns/1ps
module tccad_cable_model
   import tccad_pkg::*;
(
   // Termination per pin
   input  wire tccad_term_t term_one_in,
   input  wire tccad_term_t term_two_in,
   // Comparator levels
   output logic             one_above_out,
   output logic             one_marked_out,
   output logic             two_above_out,
   output logic             two_marked_out
);
   // Open floats high; Ra pulls below the marked level, Rd sits between
   assign one_above_out  = (term_one_in == TERM_OPEN);
   assign one_marked_out = (term_one_in == TERM_RA);
   assign two_above_out  = (term_two_in == TERM_OPEN);
   assign two_marked_out = (term_two_in == TERM_RA);
endmodule : tccad_cable_model

// >>> verification/tccad_attach_sva.sv
/*
 Port assertions for the attach block.
 Assumes one clock domain and the package timing.
*/
`timescale 1ns/1ps
module tccad_attach_sva
   import tccad_pkg::*;
(
   // Clock and reset
   input wire logic       clk_in,
   input wire logic       arst_n_in,
   // Inputs
   input wire logic       sink_role_in,
   input wire logic       regulator_at_5v_in,
   input wire logic       pin_one_above_disc_in,
   input wire logic       pin_two_above_disc_in,
   input wire logic       cc_overvoltage_in,
   // Outputs
   input wire logic [1:0] comparator_ref_out,
   input wire logic       pullup_enable_out,
   input wire logic       pullup_high_level_out,
   input wire logic       sink_pulldown_out,
   input wire logic       port_bus_power_en_out,
   input wire logic       vconn_pin_one_out,
   input wire logic       vconn_pin_two_out,
   input wire logic       pd_tx_disable_out,
   input wire logic       attached_out,
   input wire logic       orientation_out,
   input wire logic       detach_event_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   logic [DEB_W-1:0] run_cnt;
   logic             watched;
   // Raw pin run length; it leads the sync chain, so it is a safe bound
   assign watched = orientation_out ? pin_two_above_disc_in : pin_one_above_disc_in;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) run_cnt <= DEB_ZERO;
      else if (!watched) run_cnt <= DEB_ZERO;
      else if (run_cnt != 14'h3fff) run_cnt <= run_cnt + DEB_ONE;
   end
   property p_ref_snk; sink_role_in |-> comparator_ref_out == REF_SNK; endproperty
   a_ref_snk: assert property (p_ref_snk) else $error("sink reference wrong");
   property p_ref_src; !sink_role_in |-> comparator_ref_out ==
      (pullup_high_level_out ? REF_SRC_HIGH : REF_SRC_LOW); endproperty
   a_ref_src: assert property (p_ref_src) else $error("source reference wrong");
   property p_pulls; sink_pulldown_out == sink_role_in && pullup_enable_out != sink_role_in;
   endproperty
   a_pulls: assert property (p_pulls) else $error("pull terminations wrong");
   property p_level; pullup_high_level_out |-> $past(regulator_at_5v_in); endproperty
   a_level: assert property (p_level) else $error("high level before 5 V");
   property p_vconn; (vconn_pin_one_out || vconn_pin_two_out) |-> port_bus_power_en_out
      && !(vconn_pin_one_out && vconn_pin_two_out); endproperty
   a_vconn: assert property (p_vconn) else $error("vconn without bus power");
   property p_ovp; cc_overvoltage_in [*3] |=> !vconn_pin_one_out && !vconn_pin_two_out
      && pd_tx_disable_out; endproperty
   a_ovp: assert property (p_ovp) else $error("overvoltage shutdown late");
   property p_det; detach_event_out |-> (!port_bus_power_en_out && !attached_out)
      ##1 !detach_event_out; endproperty
   a_det: assert property (p_det) else $error("detach pulse wrong");
   property p_deb; $fell(attached_out) && !sink_role_in && !$past(sink_role_in)
      |-> run_cnt >= DEBOUNCE_CYCLES; endproperty
   a_deb: assert property (p_deb) else $error("detach before debounce");
endmodule : tccad_attach_sva

bind tccad_attach tccad_attach_sva i_tccad_attach_sva (.*);

// >>> verification/test_typec_cc_attach_detect.sv
/*
 Self-checking bench for the attach block with a cable model.
 Assumes a 50 MHz clock and the package debounce figure.
*/
`timescale 1ns/1ps
module test_typec_cc_attach_detect;
   import tccad_pkg::*;
   logic        clk_in = 1'b0;
   logic        arst_n_in, sink_role_in, regulator_at_5v_in, high_level_req_in;
   logic        cc_overvoltage_in, port_bus_power_present_in;
   logic        pin_one_above_disc_in, pin_one_below_marked_in;
   logic        pin_two_above_disc_in, pin_two_below_marked_in;
   logic [1:0]  partner_level_in, comparator_ref_out, partner_level_out;
   logic        pullup_enable_out, pullup_high_level_out, sink_pulldown_out;
   logic        port_bus_power_en_out, vconn_pin_one_out, vconn_pin_two_out;
   logic        pd_tx_disable_out, attached_out, orientation_out;
   logic        cable_present_out, detach_event_out;
   logic [3:0]  pw;
   tccad_term_t t1, t2;
   int          num_errors = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   tccad_cable_model i_tccad_cable_model (.term_one_in(t1), .term_two_in(t2),
      .one_above_out(pin_one_above_disc_in), .one_marked_out(pin_one_below_marked_in),
      .two_above_out(pin_two_above_disc_in), .two_marked_out(pin_two_below_marked_in));
   tccad_attach i_tccad_attach (.*);
   // Power, VCONN one, VCONN two, attached
   assign pw = {port_bus_power_en_out, vconn_pin_one_out, vconn_pin_two_out, attached_out};
   always #10 clk_in = ~clk_in;
   // Cut a hang short; two debounces fit well inside
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         conclude();
      end
   end
   task automatic conclude;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask : cyc
   // Sync chain plus state update takes about four edges
   task automatic term(input tccad_term_t a, input tccad_term_t b);
      t1 = a;
      t2 = b;
      cyc(6);
   endtask : term
   // Watched pin already open: still attached just short of the debounce
   task automatic detach;
      int n;
      n = 0;
      cyc(DEBOUNCE_CYCLES - 10);
      chk({3'h0, attached_out}, 4'h1);
      while (detach_event_out !== 1'b1 && n < 60) begin
         cyc(1);
         n++;
      end
      chk({3'h0, detach_event_out}, 4'h1);
      chk(pw, 4'h0);
      cyc(1);
   endtask : detach
   task automatic t_level;
      high_level_req_in = 1'b1;
      cyc(3);
      chk({1'b0, pullup_high_level_out, comparator_ref_out}, {2'h0, REF_SRC_LOW});
      regulator_at_5v_in = 1'b1;
      cyc(3);
      chk({1'b0, pullup_high_level_out, comparator_ref_out}, {2'h1, REF_SRC_HIGH});
   endtask : t_level
   task automatic t_sink;
      term(TERM_RD, TERM_OPEN);
      chk(pw, 4'h9);
      chk({3'h0, orientation_out}, 4'h0);
      t1 = TERM_OPEN;
      detach();
   endtask : t_sink
   task automatic t_cable_sink;
      term(TERM_RA, TERM_RD);
      chk(pw, 4'hd);
      chk({3'h0, orientation_out}, 4'h1);
      t2 = TERM_OPEN;
      detach();
   endtask : t_cable_sink
   task automatic t_cable_only;
      term(TERM_RA, TERM_OPEN);
      chk(pw, 4'h0);
      chk({3'h0, cable_present_out}, 4'h1);
      term(TERM_RA, TERM_RD);
      chk(pw, 4'hd);
      cc_overvoltage_in = 1'b1;
      cyc(4);
      chk({1'b0, vconn_pin_one_out, vconn_pin_two_out, pd_tx_disable_out}, 4'h1);
      cc_overvoltage_in = 1'b0;
   endtask : t_cable_only
   task automatic t_sink_role;
      sink_role_in = 1'b1;
      partner_level_in = 2'h2;
      term(TERM_RD, TERM_RD);
      chk({sink_pulldown_out, pullup_enable_out, comparator_ref_out}, {2'h2, REF_SNK});
      port_bus_power_present_in = 1'b1;
      cyc(6);
      chk({1'b0, attached_out, partner_level_out}, 4'h6);
   endtask : t_sink_role
   initial begin
      {arst_n_in, sink_role_in, regulator_at_5v_in, high_level_req_in} = 4'h0;
      {cc_overvoltage_in, port_bus_power_present_in, partner_level_in} = 4'h0;
      t1 = TERM_OPEN;
      t2 = TERM_OPEN;
      cyc(10);
      arst_n_in = 1'b1;
      cyc(6);
      chk(pw, 4'h0);
      t_level();
      t_sink();
      t_cable_sink();
      t_cable_only();
      t_sink_role();
      conclude();
   end
endmodule : test_typec_cc_attach_detect
